//--- asw_pkg.sv
// Constants shared by the APB memory wrapper and its write buffer
package asw_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 64;
  localparam int FIFO_DEPTH = 16;
  localparam int APB_W = 32;
  localparam int NV_PAGE = 16;
  localparam logic [11:0] NV_BASE_ADDR = 12'h800;
  localparam logic [MEM_DEPTH-1:0] WRITTEN_RESET = {MEM_DEPTH{1'b0}};
  localparam logic [APB_W-1:0] PRDATA_RESET = 32'h0000_0000;
  localparam logic [ADDR_W+DATA_W-1:0] WORD_RESET = 14'h0000;
  typedef enum logic [1:0] {
    ASW_IDLE,
    ASW_RD_DATA,
    ASW_ACK
  } asw_state_type;
endpackage

//--- asw_stream_if.sv
// Valid/ready word carrier between wrapper and buffer
`timescale 1ns/1ps
interface asw_stream_if #(
  parameter int WIDTH = 14
);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport tx (output data, output valid, input ready);
  modport rx (input data, input valid, output ready);
endinterface

//--- asw_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asw_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  asw_stream_if.rx in_s,
  asw_stream_if.tx out_s
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] wr_ptr_next;
  logic [PW:0] rd_ptr_reg;
  logic [PW:0] rd_ptr_next;
  logic full;
  logic empty;
  logic push;
  logic pop;

  always_comb begin
    empty = (wr_ptr_reg == rd_ptr_reg);
    full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
    push = in_s.valid && !full;
    pop = out_s.ready && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    in_s.ready = !full;
    out_s.valid = !empty;
    out_s.data = mem[rd_ptr_reg[PW-1:0]];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_s.data;
    end
  end
endmodule

//--- asw_wrapper.sv
// APB slave wrapper around a two-port 64x8 memory with init tracking
// How it works
// [R01] Memory read and write enables come from select, direction and enable.
// [R02] Ready stays low until the memory access is complete. Writes here get ready once the word is buffered, before it reaches the memory.
// [R03] Master keeps the bus idle, select low, when nothing is pending.
// [R04] Master holds select one setup cycle, then moves to access.
// [R05] Master raises enable; address, direction, select stay stable.
// [R06] While ready is low the master holds every transfer signal.
// [R07] After ready, master goes idle or straight to the next setup.
// [R08] First port only reads, second port only writes.
// [R09] Memory reads and writes take effect on a clock edge only.
// [R10] Initialization source holds 64 words of 8 bits.
// [R11] Master fetches the words from page 16, byte address 0x800.
// [R12] Memory contents are undefined until every location is written.
// [R13] Port-switch select rises once initialization completes.
// [R14] Init-complete is low from reset until every word is written.
// [R15] Memory is two-port, 64 words by 8 bits, wrapper on both ports.
// [R16] Low six address bits and low eight data bits are used.
// [R17] Read data is presented in the cycle ready is high.
// Writes pass through a small buffer so the bus answers in one cycle.
// Reads wait until that buffer is empty, so they never return stale data.
// The write port can be stalled; the bus then waits on a full buffer.
// Completion needs every location written once and the buffer drained.
// Write answer: ready one cycle after the access edge; read answer: two.
// Read data holds until the next read completes.
`timescale 1ns/1ps
module asw_wrapper
  import asw_pkg::*;
#(
  parameter int FIFO_D = asw_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [asw_pkg::APB_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asw_pkg::APB_W-1:0] pwdata,
  output logic [asw_pkg::APB_W-1:0] prdata,
  output logic pready,
  input wire logic wr_port_hold,
  output logic init_done,
  output logic port_sel
);
  import asw_pkg::*;

  // Buffered word: address above data
  localparam int WW = ADDR_W + DATA_W;

  // Carriers to and from the write buffer
  asw_stream_if #(.WIDTH(WW)) wr_in ();
  asw_stream_if #(.WIDTH(WW)) wr_out ();

  // Write buffer between the bus and the write port
  asw_fifo #(.WIDTH(WW), .DEPTH(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_s(wr_in),
    .out_s(wr_out)
  );

  // Memory array and bus-side state
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  asw_state_type state_reg;
  asw_state_type state_next;
  logic pready_reg;
  logic pready_next;
  logic [APB_W-1:0] prdata_reg;
  logic [APB_W-1:0] prdata_next;
  logic [DATA_W-1:0] ram_q_reg;
  logic [DATA_W-1:0] ram_q_next;

  // Completion tracking
  logic [MEM_DEPTH-1:0] written_reg;
  logic [MEM_DEPTH-1:0] written_next;
  logic done_reg;
  logic done_next;
  logic all_written;

  // Decoded bus controls
  logic access;
  logic wr_en;
  logic rd_en;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;

  // Write port, fed from the buffer
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  // Read port, fed straight from the bus
  logic mem_re;
  logic [ADDR_W-1:0] mem_raddr;

  // Only the low address and data bits reach the memory; upper bits alias
  always_comb begin
    bus_addr = paddr[ADDR_W-1:0]; // R16
    bus_wdata = pwdata[DATA_W-1:0]; // R16
  end

  // Access phase of a fresh transfer, decoded from the bus controls
  always_comb begin
    access = psel && penable && (state_reg == ASW_IDLE); // R01
    wr_en = access && pwrite && wr_in.ready; // R01 R02
    rd_en = access && !pwrite && !wr_out.valid; // R01
  end

  // Writes enter the buffer so a stalled write port blocks writes only once the buffer is full, reads as soon as it holds a word
  always_comb begin
    wr_in.valid = wr_en;
    wr_in.data = {bus_addr, bus_wdata}; // R16
    wr_out.ready = !wr_port_hold;
  end

  // Second port only writes, draining the buffer
  always_comb begin
    mem_we = wr_out.valid && !wr_port_hold; // R08
    mem_waddr = wr_out.data[WW-1:DATA_W];
    mem_wdata = wr_out.data[DATA_W-1:0];
  end

  // First port only reads, addressed by the bus
  always_comb begin
    mem_re = rd_en; // R08
    mem_raddr = bus_addr; // R16
  end

  // Bus handshake; reads wait for buffered writes so data is coherent
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    prdata_next = prdata_reg;
    case (state_reg)
      ASW_IDLE: begin
        if (wr_en) begin
          state_next = ASW_ACK;
          pready_next = 1'b1; // R02
        end else if (rd_en) begin
          state_next = ASW_RD_DATA;
        end
      end
      ASW_RD_DATA: begin
        prdata_next = {{(APB_W-DATA_W){1'b0}}, ram_q_reg}; // R17
        pready_next = 1'b1; // R02 R17
        state_next = ASW_ACK;
      end
      ASW_ACK: begin
        state_next = ASW_IDLE; // R06
      end
      default: begin
        state_next = ASW_IDLE;
      end
    endcase
  end

  // One marker per location, set when its first write lands
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_written
    assign written_next[i] = written_reg[i] || (mem_we && (mem_waddr == ADDR_W'(i))); // R12
  end

  // Done only once every location is written and the buffer is empty
  always_comb begin
    all_written = &written_reg; // R12
    done_next = done_reg || (all_written && !wr_out.valid); // R14 R13
  end

  // Bus handshake state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ASW_IDLE;
      pready_reg <= 1'b0;
      prdata_reg <= PRDATA_RESET;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
    end
  end

  // Completion map and flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      written_reg <= WRITTEN_RESET;
      done_reg <= 1'b0;
    end else begin
      written_reg <= written_next;
      done_reg <= done_next;
    end
  end

  // Read data is captured on the edge that takes the read
  always_comb begin
    ram_q_next = ram_q_reg;
    if (mem_re) begin
      ram_q_next = mem[mem_raddr]; // R08 R09
    end
  end

  // Holds between reads so the answer cycle still sees the word
  always_ff @(posedge core_clk) begin
    ram_q_reg <= ram_q_next; // R09
  end

  // Write port takes effect on the clock edge only
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata; // R08 R09 R15
    end
  end

  // Outputs are the registered values; nothing combinational reaches a pin
  always_comb begin
    prdata = prdata_reg;
    pready = pready_reg;
    init_done = done_reg; // R14
    port_sel = done_reg; // R13
  end
endmodule

//--- asw_wrapper_props.sv
// Bound checker for the APB memory wrapper
`timescale 1ns/1ps
module asw_wrapper_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic wr_port_hold,
  input wire logic init_done,
  input wire logic port_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_sel_mirror: assert property (port_sel == init_done) else $error("sel");
  a_done_sticky: assert property (init_done |=> init_done) else $error("done");
  a_done_reset: assert property ($fell(rst) |-> !init_done) else $error("rst");
  a_ready_access: assert property (
    pready |-> penable && $past(penable)) else $error("acc");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pulse");
  a_write_wait: assert property (
    (penable && pwrite && !wr_port_hold) [*2] |-> ##[0:4] pready) else $error("wr");
  a_read_late: assert property (
    pready && !pwrite |-> $past(penable, 2)) else $error("rd");
  a_rdata_hold: assert property (
    ##1 !(pready && !pwrite) |-> $stable(prdata)) else $error("hold");
  c_write: cover property (pready && pwrite);
  c_read: cover property (pready && !pwrite);
  c_done: cover property ($rose(init_done));
endmodule
bind asw_wrapper asw_wrapper_props u_props (.core_clk, .rst, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .wr_port_hold, .init_done, .port_sel);

//--- asw_apb_master.sv
// APB master model holding the init image
`timescale 1ns/1ps
module asw_apb_master (
  input wire logic core_clk,
  output logic [31:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Page 16 image at 0x800, 64 words of 8 bits
  function automatic logic [7:0] nv_word(input int i);
    return 8'h3C ^ 8'(i * 29);
  endfunction
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    psel = 1'b1;
    pwrite = w;
    paddr = {26'h2AA_AAAA, a};
    pwdata = {24'hC3C3C3, d};
    @(posedge core_clk) #1 penable = 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    #1 penable = 1'b0;
  endtask
  task automatic rel;
    psel = 1'b0;
    paddr = ~paddr;
    pwdata = ~pwdata;
    @(posedge core_clk) #1;
  endtask
endmodule

//--- asw_wrapper_test.sv
// Testbench for the APB memory wrapper
`timescale 1ns/1ps
module asw_wrapper_test;
  import asw_pkg::*;
  logic core_clk = 0, rst = 1, wr_port_hold = 0;
  logic [31:0] paddr, pwdata, prdata;
  logic psel, penable, pwrite, pready, init_done, port_sel;
  logic [7:0] q;
  int fails = 0, comparisons = 0, cyc = 0;
  asw_wrapper dut (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .wr_port_hold, .init_done, .port_sel);
  asw_apb_master bfm (.core_clk, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready);
  initial forever #20 core_clk = ~core_clk;
  task check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict;
    end
  end
  task t_init;
    check(init_done === 1'b0 && port_sel === 1'b0, "early");
    for (int i = 0; i < 64; i++) begin
      bfm.xfer(1'b1, 6'(i), bfm.nv_word(i), q);
      if (i == 62) check(init_done === 1'b0, "partial");
    end
    bfm.rel;
    repeat (4) @(posedge core_clk);
    check(init_done === 1'b1 && port_sel === 1'b1, "done");
    $display("init test done");
  endtask
  task t_read;
    for (int i = 63; i >= 0; i--) begin
      bfm.xfer(1'b0, 6'(i), 8'h00, q);
      check(q === bfm.nv_word(i), "read");
      check(prdata[31:8] === 24'h000000, "pad");
    end
    bfm.rel;
    $display("read test done");
  endtask
  task t_stall;
    wr_port_hold = 1'b1;
    for (int i = 0; i < 16; i++) bfm.xfer(1'b1, 6'(i), ~bfm.nv_word(i), q);
    fork
      bfm.xfer(1'b1, 6'h10, 8'h5A, q);
      begin
        repeat (8) begin
          @(posedge core_clk);
          check(pready === 1'b0, "full");
        end
        #1 wr_port_hold = 1'b0;
      end
    join
    bfm.xfer(1'b0, 6'h10, 8'h00, q);
    check(q === 8'h5A, "stall");
    bfm.xfer(1'b0, 6'h00, 8'h00, q);
    check(q === ~bfm.nv_word(0), "drain");
    bfm.rel;
    $display("stall test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1 t_init;
    t_read;
    t_stall;
    print_verdict;
  end
endmodule
